// ==== pmc_top.sv ====
// Purpose: Run, Idle and Sleep control, clock gating and bus divisor
// Assumes: Core and interrupt controller signals are on clk
// Notes: Registers reached over AXI4-Lite, one word each
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Wait with sleep bit clear enters Idle
// - Idle stops processor clock, source keeps running
// - Stop-in-idle peripherals halt during Idle
// - Sleep halts processor, source, bus peripherals
// - Clock monitor off in Sleep, brownout on
// - Sleep entry never clears the watchdog
// - Sleep wakes on high interrupt, reset, watchdog
// - Low interrupt in Sleep moves to Idle
// - An interrupt exits Idle only at higher priority
// - Idle exits on reset or watchdog time-out
// - Two-bit divisor picks bus ratio 1 to 8
// - Direct sysclock users ignore the divisor
// - Peripheral read completes at next bus edge
// - Crystal or PLL switch waits start-up delays
// - Idle exit applies no start-up delay
// - USB may keep fast oscillators on in Sleep
// - Sleep-capable peripherals keep their clock enable
// - Run clock selectable among six sources, crystal and PLL included
// - Pins keep driving during Sleep
module pmc_top #(
  parameter int NP = 8,
  parameter logic [7:0] SLEEP_OK = 8'h0F,
  parameter logic [17:0] OSC_START_CYC = pmc_pkg::PMC_OSC_START_CYC,
  parameter logic [17:0] PLL_LOCK_CYC = pmc_pkg::PMC_PLL_LOCK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [pmc_pkg::PMC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmc_pkg::PMC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wait_exec,
  input wire logic [2:0] cpu_prio,
  input wire logic irq_valid,
  input wire logic [2:0] irq_prio,
  input wire logic irq_in_sleep,
  input wire logic wdt_timeout,
  input wire logic usb_keep_osc,
  input wire logic periph_rd_req,
  output logic periph_rd_done,
  output logic cpu_clk_en,
  output logic sys_src_en,
  output logic [2:0] sys_src_sel,
  output logic core_system_clock_direct_en,
  output logic periph_bus_clock,
  output logic [NP-1:0] periph_clk_en,
  output logic clock_fail_monitor_en,
  output logic brownout_detector_en,
  output logic io_keep_drive,
  output logic wdt_clear
);
  import pmc_pkg::*;

  localparam int CW = PMC_CNT_W;

  typedef struct packed {
    pmc_mode_t mode;
    logic halt;
    pmc_src_t src;
    pmc_src_t tgt;
    logic [CW-1:0] cnt;
    logic slp;
    logic [1:0] div;
    pmc_src_t req;
    logic [NP-1:0] stop_in_idle;
    logic aw_got;
    logic w_got;
    logic [PMC_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic cpu_en;
    logic src_en;
    logic dir_en;
    logic pb_run;
    logic [NP-1:0] pclk;
    logic clock_fail_monitor;
    logic bor;
    logic keep;
    logic wclr;
    logic rd_pend;
    logic rd_done;
  } pmc_state_t;

  localparam pmc_state_t ST_RST = '{
    mode: PMC_RUN, src: PMC_SRC_RST, tgt: PMC_SRC_RST, req: PMC_SRC_RST,
    slp: PMC_SLP_RST, div: PMC_DIV_RST, awready: 1'b1, wready: 1'b1,
    arready: 1'b1, cpu_en: 1'b1, src_en: 1'b1, dir_en: 1'b1, pb_run: 1'b1,
    pclk: '1, clock_fail_monitor: 1'b1, bor: 1'b1, keep: 1'b1, default: '0};

  pmc_state_t st_reg;
  pmc_state_t st_next;

  logic irq_hi;
  logic wr_go;
  logic sw_slow;
  logic [CW-1:0] sw_dly;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic [31:0] osc_rd;
  logic [31:0] stat_rd;
  logic [NP-1:0] pgate;

  pmc_pb_if pb();

  pmc_pb_div u_div (
    .clk(clk),
    .rst(rst),
    .pb(pb)
  );

  assign pb.div = st_reg.div;
  assign pb.run = st_reg.pb_run;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [CW-1:0] dly_of(input pmc_src_t s);
    if (s == SRC_POSC) begin
      return OSC_START_CYC;
    end else if (s == SRC_POSC_PLL) begin
      return 18'(OSC_START_CYC + PLL_LOCK_CYC);
    end
    return '0;
  endfunction

  function automatic logic keepable(input pmc_src_t s);
    return (s != SRC_LOW_POWER_RC_OSC) && (s != SRC_SOSC);
  endfunction

  // ---------------------------------------------------------------
  // Per-peripheral clock gating
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NP; i++) begin : g_gate
    always_comb begin
      if (st_reg.mode == PMC_SLEEP) begin
        pgate[i] = SLEEP_OK[i];
      end else begin
        pgate[i] = !(st_reg.mode == PMC_IDLE && st_reg.stop_in_idle[i]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    irq_hi = irq_valid && (irq_prio > cpu_prio);
    sw_dly = dly_of(st_reg.req);
    sw_slow = (st_reg.mode == PMC_RUN) && !wait_exec && (st_reg.req != st_reg.src) &&
              (sw_dly != '0);
    wmask = {{8{st_reg.wstrb[3]}}, {8{st_reg.wstrb[2]}},
             {8{st_reg.wstrb[1]}}, {8{st_reg.wstrb[0]}}};
    osc_rd = '0;
    osc_rd[PMC_SLP_BIT] = st_reg.slp;
    osc_rd[PMC_SRC_LO +: 3] = st_reg.req;
    osc_rd[PMC_DIV_LO +: 2] = st_reg.div;
    stat_rd = '0;
    stat_rd[PMC_STAT_MODE_LO +: 2] = st_reg.mode;
    stat_rd[PMC_STAT_SRC_LO +: 3] = st_reg.src;
    stat_rd[PMC_STAT_SRCEN_BIT] = st_reg.src_en;
    stat_rd[PMC_STAT_BUSY_BIT] = (st_reg.mode == PMC_START);
    merged = (osc_rd & ~wmask) | (st_reg.wdata & wmask);
    wr_go = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    st_next = st_reg;
    st_next.wclr = 1'b0;

    unique case (st_reg.mode)
      PMC_RUN: begin
        if (wait_exec && st_reg.slp) begin
          st_next.mode = PMC_SLEEP;
        end else if (wait_exec) begin
          st_next.mode = PMC_IDLE;
        end else if (sw_slow) begin
          st_next.mode = PMC_START;
          st_next.halt = 1'b0;
          st_next.tgt = st_reg.req;
          st_next.cnt = sw_dly;
        end else if (st_reg.req != st_reg.src) begin
          st_next.src = st_reg.req;
        end
      end
      PMC_IDLE: begin
        if (irq_hi || wdt_timeout) begin
          st_next.mode = PMC_RUN;
        end
      end
      PMC_SLEEP: begin
        if (wdt_timeout || (irq_hi && irq_in_sleep)) begin
          if (!st_reg.src_en && dly_of(st_reg.src) != '0) begin
            st_next.mode = PMC_START;
            st_next.halt = 1'b1;
            st_next.tgt = st_reg.src;
            st_next.cnt = dly_of(st_reg.src);
          end else begin
            st_next.mode = PMC_RUN;
          end
        end else if (irq_valid && irq_in_sleep) begin
          st_next.mode = PMC_IDLE;
        end
      end
      PMC_START: begin
        if (st_reg.cnt == '0) begin
          st_next.mode = PMC_RUN;
          st_next.src = st_reg.tgt;
          st_next.halt = 1'b0;
        end else begin
          st_next.cnt = CW'(st_reg.cnt - 1'b1);
        end
      end
    endcase

    // Clock and power enables follow the next mode, peripheral clock gates the current one
    st_next.cpu_en = (st_next.mode == PMC_RUN) ||
                     (st_next.mode == PMC_START && !st_next.halt);
    st_next.src_en = (st_next.mode != PMC_SLEEP) ||
                     (usb_keep_osc && keepable(st_next.src));
    st_next.dir_en = (st_next.mode != PMC_SLEEP);
    st_next.pb_run = (st_next.mode != PMC_SLEEP);
    st_next.clock_fail_monitor = (st_next.mode != PMC_SLEEP);
    st_next.bor = 1'b1;
    st_next.keep = 1'b1;
    st_next.pclk = pgate;

    // Peripheral read waits for a bus clock edge
    st_next.rd_done = (st_reg.rd_pend || periph_rd_req) && pb.tick;
    st_next.rd_pend = (st_reg.rd_pend || periph_rd_req) && !pb.tick;

    // Write address and data, taken in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = PMC_RESP_OKAY;
      unique case (st_reg.waddr)
        PMC_OFS_OSC: begin
          st_next.slp = merged[PMC_SLP_BIT];
          st_next.div = merged[PMC_DIV_LO +: 2];
          if (merged[PMC_SRC_LO +: 3] <= SRC_POSC_PLL) begin
            st_next.req = pmc_src_t'(merged[PMC_SRC_LO +: 3]);
          end
        end
        PMC_OFS_STOP_IN_IDLE: begin
          st_next.stop_in_idle = (st_reg.stop_in_idle & ~wmask[NP-1:0]) |
                         (st_reg.wdata[NP-1:0] & wmask[NP-1:0]);
        end
        PMC_OFS_WDT: begin
          st_next.wclr = st_reg.wstrb[0] && st_reg.wdata[0];
        end
        PMC_OFS_STAT: begin
        end
        default: begin
          st_next.bresp = PMC_RESP_SLVERR;
        end
      endcase
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready = !st_next.w_got && !st_next.bvalid;

    // Read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = PMC_RESP_OKAY;
      unique case (s_axi_araddr)
        PMC_OFS_OSC: st_next.rdata = osc_rd;
        PMC_OFS_STOP_IN_IDLE: st_next.rdata = 32'(st_reg.stop_in_idle);
        PMC_OFS_STAT: st_next.rdata = stat_rd;
        PMC_OFS_WDT: st_next.rdata = '0;
        default: begin
          st_next.rdata = '0;
          st_next.rresp = PMC_RESP_SLVERR;
        end
      endcase
    end
    st_next.arready = !st_next.rvalid;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign periph_rd_done = st_reg.rd_done;
  assign cpu_clk_en = st_reg.cpu_en;
  assign sys_src_en = st_reg.src_en;
  assign sys_src_sel = st_reg.src;
  assign core_system_clock_direct_en = st_reg.dir_en;
  assign periph_bus_clock = pb.tick;
  assign periph_clk_en = st_reg.pclk;
  assign clock_fail_monitor_en = st_reg.clock_fail_monitor;
  assign brownout_detector_en = st_reg.bor;
  assign io_keep_drive = st_reg.keep;
  assign wdt_clear = st_reg.wclr;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_idle_entry: assert property (
    (st_reg.mode == PMC_RUN && wait_exec && !st_reg.slp)
    |=> st_reg.mode == PMC_IDLE && !cpu_clk_en) else $error("wait did not enter idle");
  a_sleep_entry: assert property (
    (st_reg.mode == PMC_RUN && wait_exec && st_reg.slp)
    |=> st_reg.mode == PMC_SLEEP) else $error("wait did not enter sleep");
  a_idle_clocks: assert property (
    st_reg.mode == PMC_IDLE |-> !cpu_clk_en && sys_src_en && core_system_clock_direct_en)
    else $error("idle clock enables wrong");
  a_stop_in_idle_gate: assert property (
    (st_reg.mode == PMC_IDLE && st_reg.stop_in_idle[0]) |=> !periph_clk_en[0])
    else $error("stop-in-idle peripheral kept running");
  a_sleep_src: assert property (
    (st_reg.mode == PMC_SLEEP && !usb_keep_osc) |=> st_reg.mode != PMC_SLEEP || !sys_src_en)
    else $error("source left running in sleep");
  a_sleep_usb: assert property (
    (st_reg.mode == PMC_SLEEP && usb_keep_osc && st_reg.src == SRC_FRC)
    |=> sys_src_en) else $error("usb hold of oscillator ignored");
  a_sleep_mon: assert property (
    st_reg.mode == PMC_SLEEP |-> !clock_fail_monitor_en && brownout_detector_en && !cpu_clk_en)
    else $error("monitor enables wrong in sleep");
  a_wdt_clear: assert property (
    wdt_clear |-> $past(wr_go) && $past(st_reg.waddr) == PMC_OFS_WDT)
    else $error("watchdog cleared without software write");
  a_sleep_wake: assert property (
    (st_reg.mode == PMC_SLEEP && irq_hi && irq_in_sleep)
    |=> st_reg.mode == PMC_RUN || st_reg.mode == PMC_START) else $error("no wake from sleep");
  a_sleep_idle: assert property (
    (st_reg.mode == PMC_SLEEP && irq_valid && irq_in_sleep && !irq_hi && !wdt_timeout)
    |=> st_reg.mode == PMC_IDLE && !cpu_clk_en ##[1:8] periph_bus_clock)
    else $error("low interrupt in sleep did not reach idle");
  a_idle_hold: assert property (
    (st_reg.mode == PMC_IDLE && !irq_hi && !wdt_timeout) |=> st_reg.mode == PMC_IDLE)
    else $error("idle left without cause");
  a_idle_exit: assert property (
    (st_reg.mode == PMC_IDLE && (wdt_timeout || irq_hi)) |=> st_reg.mode == PMC_RUN && cpu_clk_en)
    else $error("idle exit delayed");
  a_rd_done: assert property (
    periph_rd_done |-> $past(periph_bus_clock)) else $error("read done off bus edge");
  a_rd_fast: assert property (
    (periph_rd_req && periph_bus_clock) |=> periph_rd_done) else $error("read missed bus edge");
  a_switch_slow: assert property (
    sw_slow |=> st_reg.mode == PMC_START && st_reg.cnt == $past(sw_dly) && cpu_clk_en)
    else $error("no start-up delay on crystal switch");
  a_direct_clk: assert property (
    st_reg.mode != PMC_SLEEP |-> core_system_clock_direct_en) else $error("direct clock gated");
endmodule
`default_nettype wire

// ==== pmc_pkg.sv ====
// Purpose: Shared constants and types of the power mode clock controller
// Assumes: 50 MHz core system clock
// Notes: Offsets are byte addresses on the register bus
package pmc_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int PMC_CLK_MHZ = 50;
  localparam int PMC_OSC_START_US = 1000;
  localparam int PMC_PLL_LOCK_US = 100;
  localparam int PMC_CNT_W = 18;
  localparam logic [17:0] PMC_OSC_START_CYC = 18'(PMC_OSC_START_US * PMC_CLK_MHZ);
  localparam logic [17:0] PMC_PLL_LOCK_CYC = 18'(PMC_PLL_LOCK_US * PMC_CLK_MHZ);
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int PMC_AW = 4;
  localparam logic [3:0] PMC_OFS_OSC = 4'h0;
  localparam logic [3:0] PMC_OFS_STOP_IN_IDLE = 4'h4;
  localparam logic [3:0] PMC_OFS_STAT = 4'h8;
  localparam logic [3:0] PMC_OFS_WDT = 4'hC;
  localparam int PMC_SLP_BIT = 4;
  localparam int PMC_SRC_LO = 8;
  localparam int PMC_DIV_LO = 19;
  localparam int PMC_STAT_MODE_LO = 0;
  localparam int PMC_STAT_SRC_LO = 4;
  localparam int PMC_STAT_SRCEN_BIT = 8;
  localparam int PMC_STAT_BUSY_BIT = 9;
  localparam logic [1:0] PMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;
  localparam logic [1:0] PMC_DIV_RST = 2'h0;
  localparam logic PMC_SLP_RST = 1'b0;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_RUN = 2'h0,
    PMC_IDLE = 2'h1,
    PMC_SLEEP = 2'h3,
    PMC_START = 2'h2
  } pmc_mode_t;
  typedef enum logic [2:0] {
    SRC_FRC = 3'h0,
    SRC_FRC_DIV = 3'h1,
    SRC_LOW_POWER_RC_OSC = 3'h2,
    SRC_SOSC = 3'h3,
    SRC_POSC = 3'h4,
    SRC_POSC_PLL = 3'h5
  } pmc_src_t;
  localparam pmc_src_t PMC_SRC_RST = SRC_FRC;
endpackage

// ==== pmc_pb_if.sv ====
// Purpose: Carrier between the controller and its bus clock divider
// Assumes: One clock domain
// Notes: tick is a one-cycle enable per peripheral bus clock edge
`timescale 1ns/1ps
`default_nettype none
interface pmc_pb_if;
  logic [1:0] div;
  logic run;
  logic tick;
  modport ctl(output div, output run, input tick);
  modport gen(input div, input run, output tick);
endinterface
`default_nettype wire

// ==== pmc_pb_div.sv ====
// Purpose: Peripheral bus clock divider, 1:1 to 1:8
// Assumes: div and run come from flip-flops of the controller
// Notes: Counter restarts whenever run is low
`timescale 1ns/1ps
`default_nettype none
module pmc_pb_div (
  input wire logic clk,
  input wire logic rst,
  pmc_pb_if.gen pb
);
  import pmc_pkg::*;

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } pmc_div_t;

  pmc_div_t st_reg;
  pmc_div_t st_next;
  logic [2:0] lim;

  always_comb begin
    lim = 3'((4'h1 << pb.div) - 4'h1);
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!pb.run) begin
      st_next.cnt = 3'h0;
    end else if (st_reg.cnt >= lim) begin
      st_next.cnt = 3'h0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = 3'(st_reg.cnt + 3'h1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pb.tick = st_reg.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_div_eight: assert property (
    (st_reg.tick && pb.div == 2'h3 && pb.run) ##1 (pb.div == 2'h3 && pb.run) [*7]
    |=> st_reg.tick) else $error("bus clock not one in eight");
  a_div_one: assert property (
    (pb.run && pb.div == 2'h0) |=> st_reg.tick) else $error("bus clock not 1:1");
  a_div_stopped: assert property (
    !pb.run |=> !st_reg.tick) else $error("bus clock ticks while stopped");
endmodule
`default_nettype wire

// ==== pmc_core_model.sv ====
// Purpose: Processor core and interrupt controller stand-in
// Assumes: Signals change just after a rising edge
// Notes: An interrupt stays pending until the bench drops it
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
  input wire logic clk,
  output var logic wait_exec,
  output var logic [2:0] cpu_prio,
  output var logic irq_valid,
  output var logic [2:0] irq_prio,
  output var logic irq_in_sleep,
  output var logic wdt_timeout,
  output var logic periph_rd_req
);
  import pmc_pkg::*;
  initial begin
    {wait_exec, wdt_timeout, periph_rd_req} = 3'h0;
    {irq_valid, irq_in_sleep} = 2'h0;
    cpu_prio = 3'h0;
    irq_prio = 3'h0;
  end
  // One-cycle pulse: 0 wait, 1 watchdog time-out, 2 peripheral read
  task automatic pulse(input int s);
    @(posedge clk);
    {periph_rd_req, wdt_timeout, wait_exec} <= 3'(1 << s);
    @(posedge clk);
    {periph_rd_req, wdt_timeout, wait_exec} <= 3'h0;
  endtask
  // Pending interrupt and current processor priority
  task automatic irq(input logic v, input logic [2:0] p, input logic s, input logic [2:0] cp);
    @(posedge clk);
    irq_valid <= v;
    irq_prio <= p;
    irq_in_sleep <= s;
    cpu_prio <= cp;
  endtask
endmodule
`default_nettype wire

// ==== test_power_mode_clock_controller.sv ====
// Purpose: Self-checking bench of the power mode clock controller
// Assumes: Core model drives the mode inputs
// Notes: Start-up delay shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module test_power_mode_clock_controller;
  import pmc_pkg::*;
  logic clk, rst;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic wait_exec, irq_valid, irq_in_sleep, wdt_timeout, usb_keep_osc;
  logic periph_rd_req, periph_rd_done, cpu_clk_en, sys_src_en, core_system_clock_direct_en;
  logic [2:0] cpu_prio, irq_prio, sys_src_sel;
  logic periph_bus_clock, clock_fail_monitor_en, brownout_detector_en, io_keep_drive;
  logic wdt_clear;
  logic [7:0] periph_clk_en, rnd;
  int n_mismatch, num_checks, n_clr;
  pmc_top #(.OSC_START_CYC(18'h14), .PLL_LOCK_CYC(18'hA)) DUT (
    .clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wait_exec(wait_exec), .cpu_prio(cpu_prio), .irq_valid(irq_valid), .irq_prio(irq_prio),
    .irq_in_sleep(irq_in_sleep), .wdt_timeout(wdt_timeout), .usb_keep_osc(usb_keep_osc),
    .periph_rd_req(periph_rd_req), .periph_rd_done(periph_rd_done), .cpu_clk_en(cpu_clk_en),
    .sys_src_en(sys_src_en), .sys_src_sel(sys_src_sel), .core_system_clock_direct_en(core_system_clock_direct_en),
    .periph_bus_clock(periph_bus_clock), .periph_clk_en(periph_clk_en),
    .clock_fail_monitor_en(clock_fail_monitor_en),
    .brownout_detector_en(brownout_detector_en), .io_keep_drive(io_keep_drive),
    .wdt_clear(wdt_clear)
  );
  pmc_core_model core (
    .clk(clk), .wait_exec(wait_exec), .cpu_prio(cpu_prio), .irq_valid(irq_valid),
    .irq_prio(irq_prio), .irq_in_sleep(irq_in_sleep), .wdt_timeout(wdt_timeout),
    .periph_rd_req(periph_rd_req)
  );
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (wdt_clear === 1'h1) n_clr++;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] osc(input logic slp, input logic [2:0] src,
                                      input logic [1:0] dv);
    return (32'(slp) << PMC_SLP_BIT) | (32'(src) << PMC_SRC_LO) | (32'(dv) << PMC_DIV_LO);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    bh = 1'h0;
    while (!bh) begin
      @(negedge clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      s_axi_awvalid <= s_axi_awvalid && !ah;
      s_axi_wvalid <= s_axi_wvalid && !wh;
    end
    s_axi_bready <= 1'h0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    rh = 1'h0;
    while (!rh) begin
      @(negedge clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      s_axi_arvalid <= s_axi_arvalid && !ah;
    end
    s_axi_rready <= 1'h0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    int n, k, cp, lo, hi, c0;
    logic [1:0] r;
    logic [31:0] d;
    rst = 1'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    usb_keep_osc = 1'h0;
    rnd = 8'h17;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    cyc(1);
    chk(sys_src_sel, SRC_FRC);
    axr(PMC_OFS_OSC, d, r);
    chk(d, 32'h0);
    axw(4'h2, 32'h0, r);
    chk(r, PMC_RESP_SLVERR);
    axr(4'h6, d, r);
    chk({r, d[29:0]}, {PMC_RESP_SLVERR, 30'h0});
    axw(PMC_OFS_STOP_IN_IDLE, 32'hA5, r);
    for (k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      cp = rnd % 7;
      lo = rnd[7:3] % (cp + 1);
      hi = cp + 1 + rnd[7:5] % (7 - cp);
      core.irq(1'h0, 3'h0, 1'h0, 3'(cp));
      core.pulse(0);
      cyc(3);
      chk(cpu_clk_en, 1'h0);
      chk({sys_src_en, core_system_clock_direct_en}, 2'h3);
      chk(periph_clk_en, 8'h5A);
      core.irq(1'h1, 3'(lo), 1'h0, 3'(cp));
      cyc(4);
      chk(cpu_clk_en, 1'h0);
      core.irq(1'h1, 3'(hi), 1'h0, 3'(cp));
      cyc(2);
      chk(cpu_clk_en, 1'h1);
      core.irq(1'h0, 3'h0, 1'h0, 3'(cp));
    end
    core.pulse(0);
    cyc(3);
    core.pulse(1);
    cyc(3);
    chk(cpu_clk_en, 1'h1);
    c0 = n_clr;
    axw(PMC_OFS_OSC, osc(1'h1, 3'h0, 2'h0), r);
    core.irq(1'h0, 3'h0, 1'h0, 3'h4);
    core.pulse(0);
    cyc(3);
    chk({cpu_clk_en, sys_src_en, core_system_clock_direct_en}, 3'h0);
    chk(periph_clk_en, 8'h0F);
    chk({clock_fail_monitor_en, brownout_detector_en}, 2'h1);
    chk(io_keep_drive, 1'h1);
    chk(n_clr - c0, 0);
    core.irq(1'h1, 3'h2, 1'h1, 3'h4);
    cyc(3);
    chk({cpu_clk_en, sys_src_en, periph_clk_en}, 10'h15A);
    core.irq(1'h1, 3'h5, 1'h1, 3'h4);
    cyc(3);
    chk(cpu_clk_en, 1'h1);
    core.irq(1'h0, 3'h0, 1'h0, 3'h4);
    usb_keep_osc <= rnd[2];
    core.pulse(0);
    cyc(3);
    chk({cpu_clk_en, sys_src_en}, {1'h0, rnd[2]});
    core.irq(1'h1, 3'h7, 1'h0, 3'h4);
    cyc(3);
    chk(cpu_clk_en, 1'h0);
    core.irq(1'h1, 3'h5, 1'h1, 3'h4);
    cyc(3);
    chk(cpu_clk_en, 1'h1);
    core.irq(1'h0, 3'h0, 1'h0, 3'h4);
    usb_keep_osc <= 1'h0;
    core.pulse(0);
    cyc(3);
    core.pulse(1);
    cyc(3);
    chk(cpu_clk_en, 1'h1);
    axw(PMC_OFS_WDT, 32'h1, r);
    cyc(2);
    chk(n_clr - c0, 1);
    rnd = lfsr(rnd);
    s_axi_wstrb <= rnd[3:0];
    axw(PMC_OFS_STOP_IN_IDLE, 32'h5A, r);
    s_axi_wstrb <= 4'hF;
    axr(PMC_OFS_STOP_IN_IDLE, d, r);
    chk(d, rnd[0] ? 32'h5A : 32'hA5);
    for (k = 0; k < 4; k++) begin
      axw(PMC_OFS_OSC, osc(1'h0, 3'h0, 2'(k)), r);
      axr(PMC_OFS_OSC, d, r);
      chk(d, osc(1'h0, 3'h0, 2'(k)));
      repeat (2) do @(negedge clk); while (!periph_bus_clock);
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (!periph_bus_clock);
      chk(n, 1 << k);
      chk(core_system_clock_direct_en, 1'h1);
      repeat (3) begin
        rnd = lfsr(rnd);
        repeat (rnd[2:0]) @(posedge clk);
        core.pulse(2);
        n = 0;
        do begin
          @(negedge clk);
          n++;
        end while (!periph_rd_done && n < 20);
        chk(n >= 1 && n <= (1 << k), 1'h1);
        cyc(1);
        chk(periph_rd_done, 1'h0);
      end
    end
    for (k = 0; k < 4; k++) begin
      axw(PMC_OFS_OSC, osc(1'h0, 3'(k), 2'h0), r);
      cyc(2);
      chk(sys_src_sel, 3'(k));
    end
    axw(PMC_OFS_OSC, osc(1'h0, SRC_POSC, 2'h0), r);
    n = 0;
    while (sys_src_sel !== SRC_POSC && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 15 && n < 30, 1'h1);
    chk(cpu_clk_en, 1'h1);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    cyc(1);
    chk({sys_src_sel, periph_clk_en}, 11'h0FF);
    axr(PMC_OFS_STAT, d, r);
    chk(d, 32'h1 << PMC_STAT_SRCEN_BIT);
    end_sim();
  end
endmodule
`default_nettype wire
